//--- switch_status_regs.svh
// Purpose: bit positions, mode codes and reset values of the switch status word
// Assumes: 16-bit word, bit 15 leaves first on the serial output
// Notes: word bits here are 0-based, one below the printed 1..16 numbering
`ifndef SWITCH_STATUS_REGS_SVH
`define SWITCH_STATUS_REGS_SVH

`define RESP_WIDTH 16
`define RESP_MODE_HI 15
`define RESP_MODE_LO 14
`define RESP_STRAP_BIT 13
`define RESP_INT_BIT 12
`define RESP_GND_HI 11
`define RESP_GND_LO 6
`define RESP_PROG_HI 5
`define RESP_PROG_LO 2
`define RESP_BATT_HI 1
`define RESP_BATT_LO 0
`define MODE_CODE_SLEEP 2'h0
`define MODE_CODE_NORMAL 2'h1
`define MODE_CODE_POLL 2'h2
`define MODE_CODE_POLL_TIMER 2'h3
`define RESP_RESET_VALUE 16'h0000
`define SYNC_IDLE_VALUE 16'hC000
`define FRAME_SHIFTS 5'h10
`define TRI_ENABLE_RESET 12'h000

`endif

//--- switch_status_pkg.sv
// Purpose: types shared by the switch status response logic
// Assumes: mode codes live in switch_status_regs.svh
// Notes: none
package switch_status_pkg;
   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_NORMAL,
      MODE_POLL,
      MODE_POLL_TIMER
   } op_mode_e;
endpackage

//--- switch_status_spi_response.sv
// Purpose: builds and shifts out the 16-bit switch status word on every serial transfer
// Assumes: command decoding lives elsewhere and hands over run and tri-state commands on sys_clk
// Notes: serial pins, strap, reset pin and switch levels are sampled by sys_clk through two flops
//
// Summary of operation
// [R1] word bits 16:15 give mode: 01 normal, 10 polling, 11 polling with timer.
// [R2] in reset or sleep bits 16:15 are 00; other bits carry nothing defined.
// [R3] host ignores the word returned during the command that leaves sleep.
// [R4] bit 14 copies the master/slave strap pin level.
// [R5] strap bit 0 means slave, 1 means master.
// [R6] bit 13 is always the inverse of the active-low interrupt output.
// [R7] bit 13 set means this chip raised the interrupt; don't-care in polling.
// [R8] bit 13 stays set while this chip's interrupt is pending and uncleared.
// [R9] bits 12:1 hold ground 6..1, programmable 4..1, battery 2..1; 1 means closed.
// [R10] input states are captured when chip select falls and shifted for that transfer.
// [R11] a tri-stated input has wetting and sustain currents turned off.
// [R12] every tri-stated input reports 0 in its switch flag on every exchange.
// [R13] reset low clears registers and forces sleep until a serial command arrives.
`timescale 1ns/1ps
`include "switch_status_regs.svh"

module switch_status_spi_response
   import switch_status_pkg::*;
(
   // system
   input wire logic sys_clk,
   input wire logic rst,
   // device pins
   input wire logic hard_reset_n,
   input wire logic master_slave_strap,
   output logic interrupt_out_n,
   // serial link from the host
   input wire logic chip_select_n,
   input wire logic spi_sclk,
   output logic spi_so,
   output logic spi_so_oe,
   // switch comparator levels, 1 = closed
   input wire logic [5:0] ground_switch_in,
   input wire logic [3:0] programmable_switch_in,
   input wire logic [1:0] battery_switch_in,
   // from the command decoder, sys_clk domain
   input wire logic run_cmd_valid,
   input wire logic [1:0] run_cmd_mode,
   input wire logic tri_cmd_valid,
   input wire logic [11:0] tri_cmd_enable,
   input wire logic irq_pending,
   // to the input current sources
   output logic [11:0] input_current_en,
   output logic [1:0] mode_code
);

   // two-flop synchronisers, stage one read only by stage two
   logic [15:0] sync1_q;
   logic [15:0] sync2_q;
   logic [4:0] shift_cnt_q;
   logic cs_prev_q;
   logic sclk_prev_q;
   op_mode_e mode_q;
   logic [11:0] tri_en_q;
   logic [`RESP_WIDTH-1:0] shreg_q;
   logic [`RESP_WIDTH-1:0] word_d;
   logic [11:0] sw_masked;
   logic hard_rst_s;
   logic strap_s;
   logic cs_s;
   logic sclk_s;
   logic [11:0] sw_s;
   logic cs_fall;
   logic sclk_rise;

   // pins reset to their idle levels: pin reset released, deselected, serial clock low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= `SYNC_IDLE_VALUE;
         sync2_q <= `SYNC_IDLE_VALUE;
      end else begin
         sync1_q <= {hard_reset_n, chip_select_n, spi_sclk, master_slave_strap, ground_switch_in,
                     programmable_switch_in, battery_switch_in};
         sync2_q <= sync1_q;
      end
   end

   // a pin edge is seen two cycles late, so each serial clock phase must last longer
   assign hard_rst_s = sync2_q[15];
   assign cs_s = sync2_q[14];
   assign sclk_s = sync2_q[13];
   assign strap_s = sync2_q[12];
   assign sw_s = sync2_q[11:0];

   // edge detectors look at stage two only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_s;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   assign cs_fall = cs_prev_q & ~cs_s;
   assign sclk_rise = ~sclk_prev_q & sclk_s & ~cs_s;

   // operating mode; the pin reset outranks a command in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_q <= MODE_SLEEP;
      end else if (!hard_rst_s) begin
         mode_q <= MODE_SLEEP; // [R13]
      end else if (run_cmd_valid) begin
         case (run_cmd_mode)
            `MODE_CODE_NORMAL: mode_q <= MODE_NORMAL;
            `MODE_CODE_POLL: mode_q <= MODE_POLL;
            `MODE_CODE_POLL_TIMER: mode_q <= MODE_POLL_TIMER;
            // code 00 puts the block back to sleep
            default: mode_q <= MODE_SLEEP;
         endcase
      end
   end

   // tri-state enables, all inputs disabled after reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tri_en_q <= `TRI_ENABLE_RESET;
      end else if (!hard_rst_s) begin
         tri_en_q <= `TRI_ENABLE_RESET; // [R13]
      end else if (tri_cmd_valid) begin
         tri_en_q <= tri_cmd_enable;
      end
   end

   // sleep keeps the pin quiet so a stale pending flag cannot wake the host
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= ~(irq_pending && mode_q != MODE_SLEEP); // [R8]
      end
   end

   always_comb begin
      case (mode_q)
         MODE_NORMAL: mode_code = `MODE_CODE_NORMAL; // [R1]
         MODE_POLL: mode_code = `MODE_CODE_POLL; // [R1]
         MODE_POLL_TIMER: mode_code = `MODE_CODE_POLL_TIMER; // [R1]
         default: mode_code = `MODE_CODE_SLEEP; // [R2]
      endcase
   end

   // per-input masking of flags and currents
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi = gi + 1) begin : g_input
         assign sw_masked[gi] = sw_s[gi] & tri_en_q[gi]; // [R12]
         assign input_current_en[gi] = tri_en_q[gi] && mode_q != MODE_SLEEP; // [R11]
      end
   endgenerate

   always_comb begin
      word_d = `RESP_RESET_VALUE;
      if (mode_q != MODE_SLEEP) begin
         word_d[`RESP_MODE_HI:`RESP_MODE_LO] = mode_code; // [R1]
         word_d[`RESP_STRAP_BIT] = strap_s; // [R4] [R5]
         // polling reports the flag too; the host treats it as don't-care there
         word_d[`RESP_INT_BIT] = ~interrupt_out_n; // [R6] [R7]
         word_d[`RESP_GND_HI:`RESP_BATT_LO] = sw_masked; // [R9]
      end
   end

   // capture on chip select fall, shift on each rising serial clock
   // zeros fill in behind, so clocks past the sixteenth read zeros
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shreg_q <= `RESP_RESET_VALUE;
      end else if (cs_fall) begin
         shreg_q <= word_d; // [R10]
      end else if (sclk_rise) begin
         shreg_q <= {shreg_q[`RESP_WIDTH-2:0], 1'b0};
      end
   end

   // output released whenever chip select is high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         spi_so <= 1'b0;
      end else begin
         spi_so <= shreg_q[`RESP_WIDTH-1];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         spi_so_oe <= 1'b0;
      end else begin
         spi_so_oe <= ~cs_s;
      end
   end

   // shifts since select fell, kept for the framing checks
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shift_cnt_q <= 5'h00;
      end else if (cs_fall) begin
         shift_cnt_q <= 5'h00;
      end else if (sclk_rise && shift_cnt_q != `FRAME_SHIFTS) begin
         shift_cnt_q <= shift_cnt_q + 5'h01;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   mode_code_a: assert property (cs_fall && mode_q == MODE_POLL_TIMER |=> shreg_q[15:14] == 2'b11) // [R1]
      else $error("timer mode code wrong in captured word");
   sleep_word_a: assert property (cs_fall && mode_q == MODE_SLEEP |=> shreg_q == 16'h0000) // [R2]
      else $error("sleep word not zero");
   strap_copy_a: assert property (cs_fall |=> shreg_q[13] == ($past(strap_s) && $past(mode_q) != MODE_SLEEP)) // [R4]
      else $error("strap bit does not follow strap pin");
   int_flag_a: assert property (cs_fall && mode_q != MODE_SLEEP |=> shreg_q[12] == !$past(interrupt_out_n)) // [R6]
      else $error("interrupt flag not inverse of interrupt pin");
   pending_irq_a: assert property (irq_pending && mode_q != MODE_SLEEP |=> !interrupt_out_n) // [R8]
      else $error("pending interrupt not shown on pin");
   tri_zero_a: assert property (cs_fall |=> (shreg_q[11:0] & ~$past(tri_en_q)) == 12'h000) // [R12]
      else $error("disabled input reports closed");
   capture_a: assert property (cs_fall && mode_q == MODE_NORMAL |=> shreg_q[11:0] == $past(sw_s & tri_en_q)) // [R10]
      else $error("switch states not captured at select fall");
   shift_a: assert property (sclk_rise && !cs_fall |=> shreg_q == {$past(shreg_q[14:0]), 1'b0}) // [R10]
      else $error("word did not shift on serial clock");
   current_off_a: assert property ((input_current_en & ~tri_en_q) == 12'h000) // [R11]
      else $error("current on for tri-stated input");
   hard_reset_a: assert property (!hard_rst_s |=> mode_q == MODE_SLEEP && tri_en_q == 12'h000) // [R13]
      else $error("pin reset did not force sleep");
   stay_sleep_a: assert property (mode_q == MODE_SLEEP && !run_cmd_valid |=> mode_q == MODE_SLEEP) // [R13]
      else $error("left sleep without a command");

   // captured word contents
   mode_normal_a: assert property (cs_fall && mode_q == MODE_NORMAL |=> shreg_q[15:14] == 2'b01) // [R1]
      else $error("normal mode code wrong in captured word");
   mode_poll_a: assert property (cs_fall && mode_q == MODE_POLL |=> shreg_q[15:14] == 2'b10) // [R1]
      else $error("polling mode code wrong in captured word");
   strap_master_a: assert property (cs_fall && mode_q != MODE_SLEEP && strap_s |=> shreg_q[13]) // [R5]
      else $error("master strap not reported as 1");
   strap_slave_a: assert property (cs_fall && mode_q != MODE_SLEEP && !strap_s |=> !shreg_q[13]) // [R5]
      else $error("slave strap not reported as 0");
   int_origin_a: assert property (cs_fall && mode_q == MODE_NORMAL && !interrupt_out_n |=> shreg_q[12]) // [R7]
      else $error("own switch interrupt not flagged");
   timer_int_a: assert property (cs_fall && mode_q == MODE_POLL_TIMER && !interrupt_out_n |=> shreg_q[12]) // [R7]
      else $error("own wake-up interrupt not flagged");
   quiet_int_a: assert property (cs_fall && mode_q == MODE_NORMAL && interrupt_out_n |=> !shreg_q[12]) // [R7]
      else $error("interrupt flag set with pin released");
   gnd_order_a: assert property (cs_fall && mode_q != MODE_SLEEP |=> shreg_q[11:6] == $past(sw_masked[11:6])) // [R9]
      else $error("ground flags out of place");
   prog_order_a: assert property (cs_fall && mode_q != MODE_SLEEP |=> shreg_q[5:2] == $past(sw_masked[5:2])) // [R9]
      else $error("programmable flags out of place");
   batt_order_a: assert property (cs_fall && mode_q != MODE_SLEEP |=> shreg_q[1:0] == $past(sw_masked[1:0])) // [R9]
      else $error("battery flags out of place");
   capture_poll_a: assert property (cs_fall && mode_q == MODE_POLL |=> shreg_q[11:0] == $past(sw_s & tri_en_q)) // [R10]
      else $error("switch states not captured in polling");
   frame_start_a: assert property (cs_fall |=> shift_cnt_q == 5'h00 && shreg_q[15:14] == $past(mode_code)) // [R10]
      else $error("frame did not start from the captured word");

   // serial output and framing
   idle_hold_a: assert property (cs_s |=> $stable(shreg_q)) // [R10]
      else $error("word moved while deselected");
   select_oe_a: assert property (!cs_s |=> spi_so_oe) // [R10]
      else $error("output not driven while selected");
   deselect_oe_a: assert property (cs_s |=> !spi_so_oe) // [R10]
      else $error("output driven while deselected");
   so_bit_a: assert property (!cs_s |=> spi_so == $past(shreg_q[15])) // [R10]
      else $error("serial output not the word's top bit");
   frame_end_a: assert property (shift_cnt_q == `FRAME_SHIFTS |-> shreg_q == 16'h0000) // [R10]
      else $error("word not empty after sixteen shifts");

   // interrupt pin
   int_sleep_a: assert property (mode_q == MODE_SLEEP |=> interrupt_out_n) // [R8]
      else $error("interrupt pin low in sleep");
   irq_clear_a: assert property (!irq_pending |=> interrupt_out_n) // [R8]
      else $error("interrupt pin low after clear");
   pin_reset_int_a: assert property (!hard_rst_s |-> ##2 interrupt_out_n) // [R13]
      else $error("interrupt pin low after pin reset");

   // modes, currents and tri-state
   sleep_code_a: assert property (mode_q == MODE_SLEEP |-> mode_code == 2'b00) // [R2]
      else $error("sleep mode code not zero");
   mode_keep_a: assert property (hard_rst_s && !run_cmd_valid |=> $stable(mode_q)) // [R1]
      else $error("mode changed without a command");
   sleep_current_a: assert property (mode_q == MODE_SLEEP |-> input_current_en == 12'h000) // [R11]
      else $error("input current on in sleep");
   tri_load_a: assert property (hard_rst_s && tri_cmd_valid |=> tri_en_q == $past(tri_cmd_enable)) // [R12]
      else $error("tri-state command not taken");
   tri_keep_a: assert property (hard_rst_s && !tri_cmd_valid |=> $stable(tri_en_q)) // [R12]
      else $error("tri-state enables moved without a command");
   wake_cmd_a: assert property (hard_rst_s && run_cmd_valid && run_cmd_mode == 2'b01 |=> mode_q == MODE_NORMAL) // [R13]
      else $error("run command did not wake the block");

   normal_xfer_c: cover property (cs_fall && mode_q == MODE_NORMAL ##[1:400] sclk_rise);
   timer_xfer_c: cover property (cs_fall && mode_q == MODE_POLL_TIMER && !interrupt_out_n);
   frame_done_c: cover property (shift_cnt_q == `FRAME_SHIFTS && tri_en_q != 12'hFFF);
   wake_c: cover property (mode_q == MODE_SLEEP ##1 mode_q == MODE_POLL);
   irq_xfer_c: cover property (!interrupt_out_n && cs_fall);

endmodule

//--- host_spi_model.sv
// Purpose: host side of the serial link, one 16-bit frame per call
// Assumes: sclk idles low, 160 ns period
// Notes: bit sampled before each rise, while it still stands
`timescale 1ns/1ps
module host_spi_model (
   // serial link
   output logic chip_select_n,
   output logic spi_sclk,
   input wire logic spi_so
);
   initial begin
      chip_select_n = 1'h1;
      spi_sclk = 1'h0;
   end
   // sclk stands still between frames
   task automatic xfer(output logic [15:0] w);
      chip_select_n = 1'h0;
      for (int i = 15; i >= 0; i--) begin
         #80 w[i] = spi_so;
         spi_sclk = 1'h1;
         #80 spi_sclk = 1'h0;
      end
      #80 chip_select_n = 1'h1;
      #160;
   endtask
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the switch status word
// Assumes: host model drives the serial pins
// Notes: command pulses stand in for the decoder
`timescale 1ns/1ps
module testbench;
   import switch_status_pkg::*;
   logic sys_clk, rst, hard_reset_n, strap, run_v, tri_v, irq, cs_n, sclk, so, so_oe, int_n;
   logic [1:0] run_m, mode_code;
   logic [11:0] sw, tri_e, cur_en;
   logic [15:0] w;
   int miscompares, checked;
   switch_status_spi_response switch_status_spi_response_i (.sys_clk(sys_clk), .rst(rst),
      .hard_reset_n(hard_reset_n), .master_slave_strap(strap), .interrupt_out_n(int_n),
      .chip_select_n(cs_n), .spi_sclk(sclk), .spi_so(so), .spi_so_oe(so_oe),
      .ground_switch_in(sw[11:6]), .programmable_switch_in(sw[5:2]), .battery_switch_in(sw[1:0]),
      .run_cmd_valid(run_v), .run_cmd_mode(run_m), .tri_cmd_valid(tri_v), .tri_cmd_enable(tri_e),
      .irq_pending(irq), .input_current_en(cur_en), .mode_code(mode_code));
   host_spi_model host_spi_model_i (.chip_select_n(cs_n), .spi_sclk(sclk), .spi_so(so));
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // r=1 run command, else tri-state enables
   task automatic cmd(input logic r, input logic [11:0] v);
      @(posedge sys_clk) #1;
      run_v = r;
      tri_v = ~r;
      run_m = v[1:0];
      tri_e = v;
      @(posedge sys_clk) #1;
      run_v = 1'h0;
      tri_v = 1'h0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("miscompares=%0d checked=%0d", miscompares, checked);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      print_verdict;
   end
   initial begin
      rst = 1'h1;
      hard_reset_n = 1'h1;
      strap = 1'h0;
      run_v = 1'h0;
      tri_v = 1'h0;
      irq = 1'h0;
      run_m = 2'h0;
      tri_e = 12'h000;
      sw = 12'ha5c;
      repeat (4) @(posedge sys_clk);
      #1 rst = 1'h0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(16'({int_n, cur_en, mode_code}), 16'h4000);
      host_spi_model_i.xfer(w);
      chk(16'(w[15:14]), 16'h0000);
      chk(16'(so_oe), 16'h0000);
      cmd(1'h0, 12'hfff);
      for (int m = 1; m < 4; m++) begin
         strap = m[0];
         irq = m[1];
         sw = 12'ha5c + 12'(m);
         cmd(1'h1, 12'(m));
         host_spi_model_i.xfer(w);
         chk(w, {2'(m), strap, irq, sw});
         chk(16'({mode_code, int_n}), 16'({2'(m), ~irq}));
      end
      // inputs flip mid-frame; word must keep the values seen at select
      fork
         host_spi_model_i.xfer(w);
         begin
            #200 chk(16'(so_oe), 16'h0001);
            sw = ~sw;
         end
      join
      chk(w, {2'h3, strap, irq, ~sw});
      cmd(1'h0, 12'h0c3a);
      host_spi_model_i.xfer(w);
      chk(w, {2'h3, strap, irq, sw & 12'h0c3a});
      chk(16'(cur_en), 16'h0c3a);
      hard_reset_n = 1'h0;
      repeat (4) @(posedge sys_clk);
      cmd(1'h1, 12'h001);
      chk(16'({mode_code, cur_en}), 16'h0000);
      hard_reset_n = 1'h1;
      repeat (4) @(posedge sys_clk);
      #1;
      host_spi_model_i.xfer(w);
      chk(16'(w[15:14]), 16'h0000);
      // the wake command rides in a frame whose word the host throws away
      fork
         host_spi_model_i.xfer(w);
         cmd(1'h1, 12'h002);
      join
      chk(16'({mode_code, cur_en}), 16'h2000);
      host_spi_model_i.xfer(w);
      chk(w, {2'h2, strap, irq, 12'h000});
      cmd(1'h1, 12'h000);
      chk(16'({int_n, mode_code}), 16'h0004);
      print_verdict;
   end
endmodule
